// *** core/logic_pair_pkg.sv ***
// constants, register map and types of the logic pair
package logic_pair_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;
   localparam int unsigned NUM_TABLES = 2;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_SEQ = 4'h1;
   localparam logic [3:0] IDX_TABLE = 4'h5;
   localparam logic [3:0] IDX_LAST = 4'hC;
   localparam logic [3:0] IDX_STRIDE = 4'h4;
   // sub-register order inside one table block
   localparam logic [1:0] SUB_A = 2'h0;
   localparam logic [1:0] SUB_B = 2'h1;
   localparam logic [1:0] SUB_C = 2'h2;
   // field positions, masks and reset value
   localparam int unsigned EN_BIT = 0;
   localparam int unsigned LANE0 = 0;
   localparam logic [7:0] CTRL_MASK = 8'h41;
   localparam logic [7:0] TABLE_A_MASK = 8'hF9;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // filter delay bounds in table clock cycles
   localparam int unsigned FILT_MIN_CYC = 2;
   localparam int unsigned FILT_MAX_CYC = 5;
   typedef enum logic [3:0] {
      SEQ_OFF = 4'h0, SEQ_DFF = 4'h1, SEQ_JK = 4'h2,
      SEQ_LATCH = 4'h3, SEQ_RS = 4'h4
   } seq_mode_t;
   typedef enum logic [3:0] {
      SRC_MASK = 4'h0, SRC_FEEDBACK = 4'h1, SRC_LINK = 4'h2,
      SRC_EVENT_A = 4'h3, SRC_EVENT_B = 4'h4, SRC_IO = 4'h5,
      SRC_PERIPH = 4'h6
   } input_source_t;
   typedef enum logic [1:0] {
      FILT_NONE = 2'h0, FILT_SYNC = 2'h1, FILT_MAJOR = 2'h2
   } filter_t;
   typedef struct packed {
      logic edgeDetectOn;
      logic clockSourceSelect;
      filter_t filterSelect;
      logic outEnable;
      logic [1:0] spare;
      logic enable;
   } table_ctrl_a_t;
   typedef struct packed {
      logic [2:0] io;
      logic [2:0] periph;
   } table_pins_t;
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;
endpackage : logic_pair_pkg

// *** core/table_unit.sv ***
// one lookup table with filter and rising-edge detector
`timescale 1ns/1ps
module table_unit (
   input wire logic clk, // peripheral clock
   input wire logic rstN, // reset, active low
   input wire logic en, // unit and table enabled
   input wire logic_pair_pkg::table_ctrl_a_t ctrl, // control a
   input wire logic [7:0] truth, // truth value
   input wire logic [2:0] ins, // selected inputs
   output logic rawOut, // direct lookup output
   output logic finalOut, // filtered or edge output
   output logic tick // table clock event
);
   import logic_pair_pkg::*;
   logic in2Prev_r;
   logic [3:0] samp_r;
   logic filt_r;
   logic edgePrev_r;
   logic [2:0] index;
   logic filtered;
   logic agree;
   // line 2 as clock: its rising edge ticks the table
   assign tick = ctrl.clockSourceSelect ? (ins[2] & ~in2Prev_r) : 1'h1;
   assign index = {ins[2] & ~ctrl.clockSourceSelect, ins[1], ins[0]};
   assign rawOut = truth[index];
   assign agree = (samp_r[1] == samp_r[2]) && (samp_r[2] == samp_r[3]);
   // filter tap: none, two-stage sync, or three-sample agreement
   assign filtered = (ctrl.filterSelect == FILT_SYNC) ? samp_r[1] :
      (ctrl.filterSelect == FILT_MAJOR) ? filt_r : rawOut;
   assign finalOut = en & (ctrl.edgeDetectOn ?
      (filtered & ~edgePrev_r) : filtered);
   // previous level of line 2 for the clock edge
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) in2Prev_r <= 1'h0;
      else in2Prev_r <= ins[2];
   end
   // filter and detector state, cleared on the edge after disable
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         samp_r <= 4'h0;
         filt_r <= 1'h0;
         edgePrev_r <= 1'h0;
      end else if (!en) begin
         samp_r <= 4'h0;
         filt_r <= 1'h0;
         edgePrev_r <= 1'h0;
      end else if (tick) begin
         samp_r <= {samp_r[2:0], rawOut};
         if (agree) filt_r <= samp_r[1];
         edgePrev_r <= filtered;
      end
   end
endmodule : table_unit

// *** core/seq_element.sv ***
// shared sequential element of the table pair
`timescale 1ns/1ps
module seq_element (
   input wire logic clk, // peripheral clock
   input wire logic rstN, // reset, active low
   input wire logic evenEn, // even table running
   input wire logic tick, // even table clock event
   input wire logic_pair_pkg::seq_mode_t mode, // function
   input wire logic a, // even table output
   input wire logic b, // odd table output
   output logic q // element output
);
   import logic_pair_pkg::*;
   logic q_r;
   logic q_nxt;
   logic rstHold_r;
   logic clear;
   // reset held one cycle past re-enable of the even table
   assign clear = ~evenEn | rstHold_r;
   // next value per function; latches follow every cycle
   always_comb begin
      q_nxt = q_r;
      case (mode)
         SEQ_DFF: if (tick && b) q_nxt = a;
         SEQ_JK: if (tick) begin
            if (a && b) q_nxt = ~q_r;
            else if (a) q_nxt = 1'h1;
            else if (b) q_nxt = 1'h0;
         end
         SEQ_LATCH: if (b) q_nxt = a;
         SEQ_RS: begin
            if (a && !b) q_nxt = 1'h1;
            else if (b && !a) q_nxt = 1'h0;
         end
         default: q_nxt = 1'h0;
      endcase
   end
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         q_r <= 1'h0;
         rstHold_r <= 1'h1;
      end else begin
         rstHold_r <= ~evenEn;
         q_r <= clear ? 1'h0 : q_nxt;
      end
   end
   // output drops at once when the even table is disabled
   assign q = q_r & evenEn;
endmodule : seq_element

// *** core/configurable_logic_pair.sv ***
// logic pair top: bus slave, registers, input routing
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module configurable_logic_pair (
   input wire logic clk, // peripheral clock, 10 MHz
   input wire logic arst_n, // async reset, active low
   input wire logic_pair_pkg::axi_req_t axiReq, // bus requests
   output logic_pair_pkg::axi_rsp_t axiRsp, // bus answers
   input wire logic eventLineA, // event line a
   input wire logic eventLineB, // event line b
   input wire logic_pair_pkg::table_pins_t [1:0] tablePins, // inputs
   output logic [1:0] tableOut, // table outputs to events
   output logic [1:0] pinOut, // table outputs to pins
   output logic [1:0] pinOe, // pin output enables
   output logic seqOut // sequencer output
);
   import logic_pair_pkg::*;
   logic [1:0] rstSync_r;
   logic rstN;
   logic [7:0] ctrl_r;
   logic [3:0] seq_function_select_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] bresp_r;
   logic [1:0] rresp_r;
   logic [DATA_W-1:0] rdata_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic [REG_W-1:0] wByte_r;
   logic wLane_r;
   logic awTake;
   logic wTake;
   logic arTake;
   logic doWrite;
   logic [3:0] wIdx;
   logic [3:0] rIdx;
   logic wOk;
   logic rOk;
   logic wrHit;
   logic globalEn;
   logic seqQ;
   logic [7:0] rdVal;
   logic [7:0] tableRdAny;
   wire table_ctrl_a_t [NUM_TABLES-1:0] ctrlA;
   wire logic [NUM_TABLES-1:0][7:0] tableRd;
   wire logic [NUM_TABLES-1:0] rawOut;
   wire logic [NUM_TABLES-1:0] finalOut;
   wire logic [NUM_TABLES-1:0] tick;
   wire logic [NUM_TABLES-1:0] tableEn;

   // reset release through two flip-flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rstSync_r <= 2'h0;
      else rstSync_r <= {rstSync_r[0], 1'h1};
   end
   assign rstN = rstSync_r[1];

   // mapped register index check
   function automatic logic isMapped(input logic [3:0] idx);
      return idx == IDX_CTRL || idx == IDX_SEQ ||
         (idx >= IDX_TABLE && idx <= IDX_LAST);
   endfunction : isMapped

   // bus handshakes and decode
   assign awTake = axiReq.awvalid & awready_r;
   assign wTake = axiReq.wvalid & wready_r;
   assign arTake = axiReq.arvalid & arready_r;
   assign doWrite = ~awready_r & ~wready_r & ~bvalid_r;
   assign wIdx = awAddr_r[ADDR_W-1:2];
   assign rIdx = axiReq.araddr[ADDR_W-1:2];
   assign wOk = (awAddr_r[1:0] == 2'h0) && isMapped(wIdx);
   assign rOk = (axiReq.araddr[1:0] == 2'h0) && isMapped(rIdx);
   assign wrHit = doWrite & wOk & wLane_r;
   assign globalEn = ctrl_r[EN_BIT];
   assign axiRsp = '{awready: awready_r, wready: wready_r,
      bvalid: bvalid_r, bresp: bresp_r, arready: arready_r,
      rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

   // write channel: address and data in either order
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         awready_r <= 1'h1;
         wready_r <= 1'h1;
         bvalid_r <= 1'h0;
         bresp_r <= RESP_OKAY;
         awAddr_r <= '0;
         wByte_r <= REG_RESET;
         wLane_r <= 1'h0;
      end else begin
         if (awTake) begin
            awready_r <= 1'h0;
            awAddr_r <= axiReq.awaddr;
         end
         if (wTake) begin
            wready_r <= 1'h0;
            wByte_r <= axiReq.wdata[REG_W-1:0];
            wLane_r <= axiReq.wstrb[LANE0];
         end
         if (doWrite) begin
            bvalid_r <= 1'h1;
            bresp_r <= wOk ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && axiReq.bready) begin
            bvalid_r <= 1'h0;
            awready_r <= 1'h1;
            wready_r <= 1'h1;
         end
      end
   end

   // read channel: data one cycle after address
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         arready_r <= 1'h1;
         rvalid_r <= 1'h0;
         rresp_r <= RESP_OKAY;
         rdata_r <= '0;
      end else if (arTake) begin
         arready_r <= 1'h0;
         rvalid_r <= 1'h1;
         rdata_r <= DATA_W'(rdVal);
         rresp_r <= rOk ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && axiReq.rready) begin
         rvalid_r <= 1'h0;
         arready_r <= 1'h1;
      end
   end

   // read data selection
   always_comb begin
      tableRdAny = REG_RESET;
      for (int k = 0; k < NUM_TABLES; k++) tableRdAny |= tableRd[k];
   end
   assign rdVal = !rOk ? REG_RESET :
      (rIdx == IDX_CTRL) ? ctrl_r :
      (rIdx == IDX_SEQ) ? {4'h0, seq_function_select_r} : tableRdAny;

   // global control and sequencer select
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_r <= REG_RESET;
         seq_function_select_r <= 4'h0;
      end else if (wrHit) begin
         if (wIdx == IDX_CTRL) ctrl_r <= wByte_r & CTRL_MASK;
         if (wIdx == IDX_SEQ && !ctrlA[0].enable)
            seq_function_select_r <= wByte_r[3:0];
      end
   end

   genvar n, i;
   for (n = 0; n < NUM_TABLES; n++) begin : g_table
      localparam logic [3:0] BASE = IDX_TABLE + 4'(n * IDX_STRIDE);
      table_ctrl_a_t ctrlA_r;
      table_ctrl_a_t newA;
      logic [7:0] ctrlB_r;
      logic [3:0] ctrlC_r;
      logic [7:0] truth_r;
      logic hitW;
      logic hitR;
      logic [1:0] wSub;
      logic [1:0] rSub;
      logic linkIn;
      logic [2:0] ins;
      assign hitW = wrHit && wIdx >= BASE && wIdx < BASE + IDX_STRIDE;
      assign hitR = rIdx >= BASE && rIdx < BASE + IDX_STRIDE;
      assign wSub = 2'(wIdx - BASE);
      assign rSub = 2'(rIdx - BASE);
      // enabled: only the enable bit moves; else write lands with spare bits cleared
      assign newA = ctrlA_r.enable ?
         table_ctrl_a_t'({ctrlA_r[7:1], wByte_r[EN_BIT]}) :
         table_ctrl_a_t'(wByte_r & TABLE_A_MASK);
      assign ctrlA[n] = ctrlA_r;
      assign tableEn[n] = globalEn & ctrlA_r.enable;
      assign tableRd[n] = !hitR ? REG_RESET :
         (rSub == SUB_A) ? 8'(ctrlA_r) :
         (rSub == SUB_B) ? ctrlB_r :
         (rSub == SUB_C) ? {4'h0, ctrlC_r} : truth_r;
      // table registers
      always_ff @(posedge clk or negedge rstN) begin
         if (!rstN) begin
            ctrlA_r <= table_ctrl_a_t'(REG_RESET);
            ctrlB_r <= REG_RESET;
            ctrlC_r <= 4'h0;
            truth_r <= REG_RESET;
         end else if (hitW) begin
            if (wSub == SUB_A) ctrlA_r <= newA;
            else if (wSub == SUB_B && !ctrlA_r.enable)
               ctrlB_r <= wByte_r;
            else if (wSub == SUB_C && !ctrlA_r.enable)
               ctrlC_r <= wByte_r[3:0];
            else if (wSub != SUB_B && wSub != SUB_C)
               truth_r <= wByte_r;
         end
      end
      // link from the next table; the last table has none
      if (n + 1 < NUM_TABLES) begin : g_link
         assign linkIn = rawOut[n+1];
      end else begin : g_nolink
         assign linkIn = 1'h0;
      end
      // source selection per input line
      for (i = 0; i < 3; i++) begin : g_in
         input_source_t src;
         assign src = input_source_t'((i == 2) ? ctrlC_r :
            (i == 1) ? ctrlB_r[7:4] : ctrlB_r[3:0]);
         assign ins[i] = (src == SRC_FEEDBACK) ? seqQ :
            (src == SRC_LINK) ? linkIn :
            (src == SRC_EVENT_A) ? eventLineA :
            (src == SRC_EVENT_B) ? eventLineB :
            (src == SRC_IO) ? tablePins[n].io[i] :
            (src == SRC_PERIPH) ? tablePins[n].periph[i] : 1'h0;
      end
      table_unit u_table (
         .clk(clk),
         .rstN(rstN),
         .en(tableEn[n]),
         .ctrl(ctrlA_r),
         .truth(truth_r),
         .ins(ins),
         .rawOut(rawOut[n]),
         .finalOut(finalOut[n]),
         .tick(tick[n])
      );
      // registered outputs
      always_ff @(posedge clk or negedge rstN) begin
         if (!rstN) begin
            tableOut[n] <= 1'h0;
            pinOut[n] <= 1'h0;
            pinOe[n] <= 1'h0;
         end else begin
            tableOut[n] <= finalOut[n];
            pinOut[n] <= finalOut[n] & ctrlA_r.outEnable;
            pinOe[n] <= tableEn[n] & ctrlA_r.outEnable;
         end
      end
   end

   // sequencer on the even table clock, fed by final outputs
   seq_element u_seq (
      .clk(clk),
      .rstN(rstN),
      .evenEn(tableEn[0]),
      .tick(tick[0]),
      .mode(seq_mode_t'(seq_function_select_r)),
      .a(finalOut[0]),
      .b(finalOut[1]),
      .q(seqQ)
   );
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) seqOut <= 1'h0;
      else seqOut <= seqQ;
   end

   // checks
   sequence evenLocked;
      wrHit && wIdx == IDX_SEQ && ctrlA[0].enable;
   endsequence
   sequence syncRun;
      tableEn[0] && !ctrlA[0].clockSourceSelect &&
         ctrlA[0].filterSelect == FILT_SYNC;
   endsequence
   sequence reEnable;
      !tableEn[0] ##1 tableEn[0];
   endsequence
   seq_protect_a: assert property (@(posedge clk) disable iff (!rstN)
      evenLocked |=> $stable(seq_function_select_r))
      else $error("sequencer select changed while locked");
   ctrl_protect_a: assert property (@(posedge clk) disable iff (!rstN)
      wrHit && wIdx == IDX_TABLE && ctrlA[0].enable
      |=> ctrlA[0][7:1] == $past(ctrlA[0][7:1]))
      else $error("locked table fields changed");
   enable_write_a: assert property (@(posedge clk) disable iff (!rstN)
      wrHit && wIdx == IDX_TABLE && !ctrlA[0].enable
      |=> 8'(ctrlA[0]) == ($past(wByte_r) & TABLE_A_MASK))
      else $error("enabling write lost its fields");
   global_off_a: assert property (@(posedge clk) disable iff (!rstN)
      !globalEn |=> tableOut == 2'h0)
      else $error("output active while unit off");
   sync_delay_a: assert property (@(posedge clk) disable iff (!rstN)
      syncRun [*3] ##0 !ctrlA[0].edgeDetectOn
      |-> finalOut[0] == $past(rawOut[0], 2))
      else $error("sync filter delay wrong");
   edge_once_a: assert property (@(posedge clk) disable iff (!rstN)
      tableEn[0] && ctrlA[0].edgeDetectOn &&
      !ctrlA[0].clockSourceSelect && finalOut[0]
      |=> !finalOut[0])
      else $error("edge pulse longer than one cycle");
   seq_clear_a: assert property (@(posedge clk) disable iff (!rstN)
      reEnable |=> !seqQ)
      else $error("sequencer not held in reset");
   link_route_a: assert property (@(posedge clk) disable iff (!rstN)
      g_table[0].g_in[0].src == SRC_LINK
      |-> g_table[0].ins[0] == rawOut[1])
      else $error("link input not from next table");
   jk_toggle_a: assert property (@(posedge clk) disable iff (!rstN)
      seq_function_select_r == SEQ_JK && tableEn[0] && $past(tableEn[0]) &&
      tick[0] && finalOut[0] && finalOut[1]
      |=> !tableEn[0] || seqQ != $past(seqQ))
      else $error("JK did not toggle");
   rs_hold_a: assert property (@(posedge clk) disable iff (!rstN)
      seq_function_select_r == SEQ_RS && tableEn[0] && $past(tableEn[0]) &&
      finalOut[0] && finalOut[1] ##1 tableEn[0] |-> $stable(seqQ))
      else $error("RS with both inputs high moved");
endmodule : configurable_logic_pair

// *** sim/pin_source_model.sv ***
// partner model: device pins, peripheral outputs and event lines
`timescale 1ns/1ps
module pin_source_model (
   input wire logic clk, // peripheral clock
   input wire logic [5:0] levels, // pin levels, table 1 in [5:3]
   input wire logic [1:0] events, // requested event levels
   output logic_pair_pkg::table_pins_t [1:0] pins, // table inputs
   output logic eventA, // event line a
   output logic eventB // event line b
);
   import logic_pair_pkg::*;
   // pins follow the levels, peripherals show the inverse
   assign pins[0] = {levels[2:0], ~levels[2:0]};
   assign pins[1] = {levels[5:3], ~levels[5:3]};
   // event lines change only just after a clock edge
   always_ff @(posedge clk) begin
      eventA <= events[0];
      eventB <= events[1];
   end
endmodule : pin_source_model

// *** sim/configurable_logic_pair_bench.sv ***
// self-checking bench of the logic pair
`timescale 1ns/1ps
module configurable_logic_pair_bench;
   import logic_pair_pkg::*;
   localparam logic [7:0] XOR3 = 8'h96;
   localparam logic [6:0] STEPS [19] = '{7'h15, 7'h11, 7'h12, 7'h15,
      7'h0A, 7'h0C, 7'h0F, 7'h09, 7'h1A, 7'h1C, 7'h1F, 7'h19,
      7'h25, 7'h21, 7'h27, 7'h22, 7'h25, 7'h06, 7'h2C};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   axi_req_t req = '0;
   axi_rsp_t rsp;
   logic [5:0] levels = 6'h00;
   logic [1:0] events = 2'h0;
   table_pins_t [1:0] pins;
   logic evA;
   logic evB;
   logic [1:0] tableOut;
   logic [1:0] pinOut;
   logic [1:0] pinOe;
   logic seqOut;
   logic [1:0] resp;
   logic [31:0] rdat;
   int numErrors = 0;
   int nTests = 0;
   int cycles = 0;

   configurable_logic_pair dut (.clk(clk), .arst_n(arst_n), .axiReq(req),
      .axiRsp(rsp), .eventLineA(evA), .eventLineB(evB), .tablePins(pins),
      .tableOut(tableOut), .pinOut(pinOut), .pinOe(pinOe), .seqOut(seqOut));
   pin_source_model partner (.clk(clk), .levels(levels), .events(events),
      .pins(pins), .eventA(evA), .eventB(evB));

   // clock of 100 ns
   always #50 clk = ~clk;

   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         numErrors++;
         finishTest();
      end
   end

   task automatic finishTest();
      $display("comparisons %0d mismatches %0d", nTests, numErrors);
      if (numErrors == 0 && nTests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finishTest

   task automatic chk(input string what, input logic [31:0] exp, got);
      nTests++;
      if (got !== exp) begin
         numErrors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // one bus write; address and data held until each is taken
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= {idx, 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= {24'h00_0000, d};
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      while (!(a && w)) begin
         @(posedge clk);
         if (req.awvalid && rsp.awready) begin
            a = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (req.wvalid && rsp.wready) begin
            w = 1'b1;
            req.wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (rsp.bvalid !== 1'b1);
      resp = rsp.bresp;
      req.bready <= 1'b0;
      chk("write response", 32'(RESP_OKAY), 32'(resp));
   endtask : wr

   // one bus read, data and response compared
   task automatic rd(input logic [3:0] idx, input logic [7:0] exp,
         input logic [1:0] er);
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= {idx, 2'b00};
      req.rready <= 1'b1;
      do @(posedge clk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge clk); while (rsp.rvalid !== 1'b1);
      rdat = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
      chk("read data", {24'h00_0000, exp}, rdat);
      chk("read response", 32'(er), 32'(resp));
   endtask : rd

   task automatic testReset();
      for (int i = 0; i < 13; i++) begin
         if (i < 2 || i > 4) rd(4'(i), 8'h00, RESP_OKAY);
      end
      rd(4'h3, 8'h00, RESP_SLVERR);
      rd(4'hD, 8'h00, RESP_SLVERR);
      $display("reset values done");
   endtask : testReset

   task automatic testTruth();
      wr(IDX_CTRL, 8'h01);
      wr(4'h6, 8'h55);
      wr(4'h7, 8'h05);
      wr(4'h8, XOR3);
      wr(4'h5, 8'h09);
      for (int v = 0; v < 8; v++) begin
         levels <= 6'(v);
         cyc(4);
         chk("table output", 32'(XOR3[v]), 32'(tableOut[0]));
         chk("pin output", 32'(XOR3[v]), 32'(pinOut[0]));
      end
      wr(IDX_CTRL, 8'h00);
      cyc(3);
      chk("pin enable off", 32'(1'b0), 32'(pinOe[0]));
      wr(IDX_CTRL, 8'h01);
      cyc(3);
      chk("pin enable on", 32'(1'b1), 32'(pinOe[0]));
      $display("truth table done");
   endtask : testTruth

   task automatic testProtect();
      int n;
      wr(4'h6, 8'h00);
      rd(4'h6, 8'h55, RESP_OKAY);
      wr(IDX_SEQ, 8'h02);
      rd(IDX_SEQ, 8'h00, RESP_OKAY);
      wr(4'h5, 8'h18);
      rd(4'h5, 8'h08, RESP_OKAY);
      wr(4'h5, 8'h99);
      rd(4'h5, 8'h99, RESP_OKAY);
      levels <= 6'h00;
      cyc(10);
      levels <= 6'h01;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tableOut[0] !== 1'b1 && n < 12);
      chk("filter delay", 32'(1'b1), 32'(n >= 4 && n <= 7));
      @(posedge clk);
      chk("edge pulse end", 32'(1'b0), 32'(tableOut[0]));
      cyc(5);
      chk("edge level held", 32'(1'b0), 32'(tableOut[0]));
      $display("protection and filter done");
   endtask : testProtect

   task automatic testLink();
      wr(4'h5, 8'h00);
      wr(4'h6, 8'h32);
      wr(4'h7, 8'h04);
      wr(4'h5, 8'h09);
      wr(4'hA, 8'h55);
      wr(4'hB, 8'h05);
      wr(4'hC, XOR3);
      wr(4'h9, 8'h09);
      for (int i = 0; i < 32; i++) begin
         levels <= {i[2:0], 3'h0};
         events <= i[4:3];
         cyc(4);
         chk("odd output", 32'(XOR3[i[2:0]]), 32'(tableOut[1]));
         chk("linked output", 32'(XOR3[i[2:0]] ^ i[3] ^ i[4]),
            32'(tableOut[0]));
      end
      $display("link and events done");
   endtask : testLink

   task automatic testSeq();
      logic [3:0] prev;
      wr(4'h9, 8'h00);
      wr(4'hA, 8'h05);
      wr(4'hB, 8'h00);
      wr(4'hC, 8'hAA);
      wr(4'h9, 8'h01);
      wr(4'h5, 8'h00);
      wr(4'h6, 8'h05);
      wr(4'h7, 8'h00);
      wr(4'h8, 8'hAA);
      prev = 4'hF;
      foreach (STEPS[k]) begin
         if (STEPS[k][6:3] != prev) begin
            wr(4'h5, 8'h00);
            cyc(2);
            chk("seq cleared", 32'(1'b0), 32'(seqOut));
            wr(IDX_SEQ, {4'h0, STEPS[k][6:3]});
            wr(4'h5, 8'h01);
            prev = STEPS[k][6:3];
         end
         levels <= {2'h0, STEPS[k][1], 2'h0, STEPS[k][2]};
         cyc(5);
         chk("seq output", 32'(STEPS[k][0]),
            32'(seqOut));
      end
      $display("sequential modes done");
   endtask : testSeq

   // feedback into the odd table, then line 2 used as table clock
   task automatic testRoute();
      wr(4'h9, 8'h00);
      wr(4'hA, 8'h01);
      wr(4'h9, 8'h09);
      wr(4'h5, 8'h00);
      wr(IDX_SEQ, 8'h04);
      wr(4'h5, 8'h01);
      levels <= 6'h01;
      cyc(5);
      chk("feedback high", 32'(1'b1), 32'(tableOut[1]));
      levels <= 6'h00;
      cyc(5);
      chk("feedback low", 32'(1'b0), 32'(tableOut[1]));
      wr(4'h9, 8'h00);
      wr(4'hA, 8'h00);
      wr(4'hB, 8'h05);
      wr(4'hC, 8'hF0);
      wr(4'h9, 8'h49);
      levels <= 6'h20;
      cyc(5);
      chk("line 2 masked", 32'(1'b0), 32'(tableOut[1]));
      $display("routing done");
   endtask : testRoute

   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      testReset();
      testTruth();
      testProtect();
      testLink();
      testSeq();
      testRoute();
      finishTest();
   end
endmodule : configurable_logic_pair_bench
